// [rtl/fpc_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface fpc_bus_if;
    import fpc_pkg::*;
    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;

    modport dev(input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
    modport host(output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

// [rtl/fpc_device.sv]
`timescale 1ns/1ps
`default_nettype none
module fpc_device
    import fpc_pkg::*;
#(
    parameter int SUSP_LAT_CYC = SUSP_LAT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    fpc_bus_if.dev bus,
    input wire logic prog_start,
    input wire logic prog_done,
    input wire logic abort_event,
    input wire logic [DATA_W-1:0] array_data,
    output logic busy,
    output logic suspended,
    output logic lock_prog,
    output logic [DATA_W-1:0] lock_data,
    output logic [DATA_W-1:0] status_word
);
    localparam int LAT_W = $clog2(SUSP_LAT_CYC + 1);
    localparam logic [LAT_W-1:0] LAT_LAST = LAT_W'(SUSP_LAT_CYC - 1);

    if (SUSP_LAT_CYC < 1) begin : g_lat_chk
        $error("SUSP_LAT_CYC must be at least one");
    end

    fpc_state_e state;
    fpc_state_e next_state;
    fpc_state_e ret_state;
    fpc_state_e next_ret_state;
    logic [LAT_W-1:0] lat_cnt;
    logic [LAT_W-1:0] next_lat_cnt;
    logic abort_flag;
    logic next_abort_flag;
    logic sr_clear;
    logic [DATA_W-1:0] next_rdata;
    logic next_rvalid;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic next_lock_prog;
    logic [DATA_W-1:0] next_lock_data;
    logic wr;
    logic at_cmd1;
    logic at_cmd2;
    logic [DATA_W-1:0] d;
    logic in_sr_read;

    assign wr = bus.wr_en;
    assign d = bus.wdata;
    assign at_cmd1 = (bus.addr == ADDR_CMD1);
    assign at_cmd2 = (bus.addr == ADDR_CMD2);
    assign bus.rdata = rdata;
    assign bus.rvalid = rvalid;
    assign in_sr_read = (state == FPC_PROGRAM_STATUS_READ)
        || (state == FPC_SUSPENDED_STATUS_READ)
        || (state == FPC_LOCK_STATUS_READ);

    // Status word
    always_comb begin
        status_word = '0;
        status_word[SR_READY_BIT] = !((state == FPC_PROGRAMMING)
            || (state == FPC_SUSPEND_PENDING)
            || ((state == FPC_PROGRAM_STATUS_READ)
                && ((ret_state == FPC_PROGRAMMING) || (ret_state == FPC_SUSPEND_PENDING))));
        status_word[SR_ABORT_BIT] = abort_flag;
        status_word[SR_SUSP_BIT] = (state == FPC_PROGRAM_SUSPENDED)
            || (state == FPC_SUSPENDED_STATUS_READ);
    end

    assign busy = (state == FPC_PROGRAMMING) || (state == FPC_SUSPEND_PENDING);
    assign suspended = (state == FPC_PROGRAM_SUSPENDED)
        || (state == FPC_SUSPENDED_STATUS_READ);

    // Command state machine
    always_comb begin
        next_state = state;
        next_ret_state = ret_state;
        next_lat_cnt = '0;
        sr_clear = 1'b0;
        next_lock_prog = 1'b0;
        next_lock_data = lock_data;
        case (state)
            FPC_READ: begin
                if (prog_start) begin
                    next_state = FPC_PROGRAMMING;
                end else if (wr && at_cmd1 && (d == CMD_LOCK_ENTER)) begin
                    next_state = FPC_LOCK_CMD_SET;
                end else if (wr && at_cmd1 && (d == CMD_SR_CLEAR)) begin
                    sr_clear = 1'b1;
                end
            end
            FPC_PROGRAMMING: begin
                if (prog_done) begin
                    next_state = FPC_READ;
                end else if (abort_event) begin
                    next_state = FPC_ABORT_PENDING;
                end else if (wr && ((d == CMD_SUSP_ENH) || (d == CMD_SUSP_LEGACY))) begin
                    next_state = FPC_SUSPEND_PENDING;
                end else if (wr && at_cmd1 && (d == CMD_SR_READ)) begin
                    next_state = FPC_PROGRAM_STATUS_READ;
                    next_ret_state = FPC_PROGRAMMING;
                end
            end
            FPC_ABORT_PENDING: begin
                if (wr && (d == CMD_RESET)) begin
                    next_state = FPC_READ;
                    sr_clear = 1'b1;
                end else if (wr && at_cmd1 && (d == CMD_UNLOCK1)) begin
                    next_state = FPC_ABORT_UNLOCK_FIRST;
                end else if (wr && at_cmd1 && (d == CMD_SR_READ)) begin
                    next_state = FPC_PROGRAM_STATUS_READ;
                    next_ret_state = FPC_ABORT_PENDING;
                end
            end
            FPC_ABORT_UNLOCK_FIRST: begin
                if (wr && at_cmd2 && (d == CMD_UNLOCK2)) begin
                    next_state = FPC_ABORT_UNLOCK_SECOND;
                end else if (wr) begin
                    next_state = abort_flag ? FPC_ABORT_PENDING : FPC_PROGRAMMING;
                end
            end
            FPC_ABORT_UNLOCK_SECOND: begin
                if (wr && (d == CMD_RESET)) begin
                    next_state = FPC_READ;
                    sr_clear = 1'b1;
                end else if (wr) begin
                    next_state = FPC_PROGRAMMING;
                end
            end
            FPC_PROGRAM_STATUS_READ: begin
                if (prog_done && (ret_state == FPC_PROGRAMMING)) begin
                    next_ret_state = FPC_READ;
                end
                if (ret_state == FPC_SUSPEND_PENDING) begin
                    next_lat_cnt = (lat_cnt == LAT_LAST) ? lat_cnt : LAT_W'(lat_cnt + 1'b1);
                    if (lat_cnt == LAT_LAST) begin
                        next_ret_state = FPC_PROGRAM_SUSPENDED;
                    end
                end
                if (bus.rd_en) begin
                    next_state = next_ret_state;
                end
            end
            FPC_SUSPEND_PENDING: begin
                next_lat_cnt = LAT_W'(lat_cnt + 1'b1);
                if (lat_cnt == LAT_LAST) begin
                    next_state = FPC_PROGRAM_SUSPENDED;
                    next_lat_cnt = '0;
                end else if (wr && at_cmd1 && (d == CMD_SR_READ)) begin
                    next_state = FPC_PROGRAM_STATUS_READ;
                    next_ret_state = FPC_SUSPEND_PENDING;
                end
            end
            FPC_PROGRAM_SUSPENDED: begin
                if (wr && at_cmd1 && (d == CMD_SR_READ)) begin
                    next_state = FPC_SUSPENDED_STATUS_READ;
                    next_ret_state = FPC_PROGRAM_SUSPENDED;
                end else if (wr && at_cmd1 && (d == CMD_SR_CLEAR)) begin
                    sr_clear = 1'b1;
                end else if (wr && ((d == CMD_RESUME_ENH) || (d == CMD_RESUME_LEGACY))) begin
                    next_state = FPC_PROGRAMMING;
                end
            end
            FPC_SUSPENDED_STATUS_READ: begin
                if (bus.rd_en) begin
                    next_state = ret_state;
                end
            end
            FPC_LOCK_CMD_SET: begin
                if (wr && (d == CMD_RESET)) begin
                    next_state = FPC_READ;
                end else if (wr && at_cmd1 && (d == CMD_SR_READ)) begin
                    next_state = FPC_LOCK_STATUS_READ;
                    next_ret_state = FPC_LOCK_CMD_SET;
                end else if (wr && at_cmd1 && (d == CMD_SR_CLEAR)) begin
                    sr_clear = 1'b1;
                end else if (wr && (d == CMD_EXIT_ENTRY)) begin
                    next_state = FPC_LOCK_CMD_SET_EXIT;
                end else if (wr && (d == CMD_LOCK_PGM)) begin
                    next_state = FPC_LOCK_BIT_PROGRAM_ENTRY;
                end
            end
            FPC_LOCK_BIT_PROGRAM_ENTRY: begin
                if (wr) begin
                    next_lock_prog = 1'b1;
                    next_lock_data = d;
                    next_state = FPC_LOCK_CMD_SET;
                end
            end
            FPC_LOCK_STATUS_READ: begin
                if (bus.rd_en) begin
                    next_state = ret_state;
                end
            end
            FPC_LOCK_CMD_SET_EXIT: begin
                if (wr && (d == CMD_EXIT)) begin
                    next_state = FPC_READ;
                end
            end
            default: begin
                next_state = FPC_READ;
            end
        endcase
    end

    // Abort flag, set wins over clear
    always_comb begin
        next_abort_flag = abort_flag;
        if (sr_clear) begin
            next_abort_flag = 1'b0;
        end
        if (abort_event && (state == FPC_PROGRAMMING)) begin
            next_abort_flag = 1'b1;
        end
    end

    // Read answer
    always_comb begin
        next_rvalid = bus.rd_en;
        next_rdata = rdata;
        if (bus.rd_en) begin
            next_rdata = in_sr_read ? status_word : array_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= FPC_READ;
            ret_state <= FPC_READ;
            lat_cnt <= '0;
            abort_flag <= 1'b0;
            rdata <= RDATA_RST;
            rvalid <= 1'b0;
            lock_prog <= 1'b0;
            lock_data <= RDATA_RST;
        end else begin
            state <= next_state;
            ret_state <= next_ret_state;
            lat_cnt <= next_lat_cnt;
            abort_flag <= next_abort_flag;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            lock_prog <= next_lock_prog;
            lock_data <= next_lock_data;
        end
    end
endmodule
`default_nettype wire

// [rtl/fpc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module fpc_host
    import fpc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    fpc_bus_if.host bus,
    input wire logic cmd_valid,
    input wire logic cmd_rd,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [DATA_W-1:0] resp_data
);
    fpc_host_state_e state;
    fpc_host_state_e next_state;
    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic next_wr_en;
    logic next_rd_en;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_wdata;
    logic next_resp_valid;
    logic [DATA_W-1:0] next_resp_data;

    assign cmd_ready = (state == FPC_H_IDLE);
    assign bus.wr_en = wr_en;
    assign bus.rd_en = rd_en;
    assign bus.addr = addr;
    assign bus.wdata = wdata;

    always_comb begin
        next_state = state;
        next_wr_en = 1'b0;
        next_rd_en = 1'b0;
        next_addr = addr;
        next_wdata = wdata;
        next_resp_valid = 1'b0;
        next_resp_data = resp_data;
        case (state)
            FPC_H_IDLE: begin
                if (cmd_valid) begin
                    next_addr = cmd_addr;
                    next_wdata = cmd_data;
                    if (cmd_rd) begin
                        next_rd_en = 1'b1;
                        next_state = FPC_H_WAIT;
                    end else begin
                        next_wr_en = 1'b1;
                    end
                end
            end
            FPC_H_WAIT: begin
                // One read closes a status read on the device
                if (bus.rvalid) begin
                    next_resp_valid = 1'b1;
                    next_resp_data = bus.rdata;
                    next_state = FPC_H_IDLE;
                end
            end
            default: begin
                next_state = FPC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= FPC_H_IDLE;
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            addr <= ADDR_RST;
            wdata <= RDATA_RST;
            resp_valid <= 1'b0;
            resp_data <= RDATA_RST;
        end else begin
            state <= next_state;
            wr_en <= next_wr_en;
            rd_en <= next_rd_en;
            addr <= next_addr;
            wdata <= next_wdata;
            resp_valid <= next_resp_valid;
            resp_data <= next_resp_data;
        end
    end
endmodule
`default_nettype wire

// [rtl/fpc_pkg.sv]
`default_nettype none
package fpc_pkg;
    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Command addresses
    localparam logic [ADDR_W-1:0] ADDR_CMD1 = 12'h0555;
    localparam logic [ADDR_W-1:0] ADDR_CMD2 = 12'h02AA;

    // Command codes
    localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
    localparam logic [DATA_W-1:0] CMD_SR_READ = 8'h70;
    localparam logic [DATA_W-1:0] CMD_SR_CLEAR = 8'h71;
    localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_SUSP_ENH = 8'h51;
    localparam logic [DATA_W-1:0] CMD_SUSP_LEGACY = 8'hB0;
    localparam logic [DATA_W-1:0] CMD_RESUME_ENH = 8'h50;
    localparam logic [DATA_W-1:0] CMD_RESUME_LEGACY = 8'h30;
    localparam logic [DATA_W-1:0] CMD_LOCK_ENTER = 8'h40;
    localparam logic [DATA_W-1:0] CMD_EXIT_ENTRY = 8'h90;
    localparam logic [DATA_W-1:0] CMD_EXIT = 8'h00;
    localparam logic [DATA_W-1:0] CMD_LOCK_PGM = 8'hA0;

    // Status word bit positions
    localparam int SR_READY_BIT = 7;
    localparam int SR_ABORT_BIT = 3;
    localparam int SR_SUSP_BIT = 2;

    // Suspend latency
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SUSP_LATENCY_NS = 20000;
    localparam int SUSP_LAT_CYCLES = (SUSP_LATENCY_NS * 1000) / CLK_PERIOD_PS;

    // Reset values
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h0000;

    typedef enum logic [12:0] {
        FPC_READ = 13'h0001,
        FPC_PROGRAMMING = 13'h0002,
        FPC_ABORT_PENDING = 13'h0004,
        FPC_ABORT_UNLOCK_FIRST = 13'h0008,
        FPC_ABORT_UNLOCK_SECOND = 13'h0010,
        FPC_PROGRAM_STATUS_READ = 13'h0020,
        FPC_SUSPEND_PENDING = 13'h0040,
        FPC_PROGRAM_SUSPENDED = 13'h0080,
        FPC_SUSPENDED_STATUS_READ = 13'h0100,
        FPC_LOCK_CMD_SET = 13'h0200,
        FPC_LOCK_CMD_SET_EXIT = 13'h0400,
        FPC_LOCK_BIT_PROGRAM_ENTRY = 13'h0800,
        FPC_LOCK_STATUS_READ = 13'h1000
    } fpc_state_e;

    typedef enum logic [1:0] {
        FPC_H_IDLE = 2'h1,
        FPC_H_WAIT = 2'h2
    } fpc_host_state_e;
endpackage
`default_nettype wire

// [sim/fpc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module fpc_checker
    import fpc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_RVALID_AFTER_RD: assert property (rd_en |=> rvalid)
        else $error("read strobe without answer next cycle");
    AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd_en))
        else $error("answer without read strobe");
    AST_RVALID_PULSE: assert property (rvalid |=> !rvalid)
        else $error("answer longer than one cycle");
    AST_RDATA_HOLD: assert property (!rvalid |-> $stable(rdata))
        else $error("read data moved without answer");
    AST_RD_WR_EXCL: assert property (!(wr_en && rd_en))
        else $error("read and write strobes together");
    AST_READ_BLOCKS: assert property (rd_en |=> (!rd_en && !wr_en) [*2])
        else $error("bus cycle issued while read pending");
    AST_RESET_IDLE: assert property ($rose(nrst) |-> !wr_en && !rd_en && !rvalid)
        else $error("bus not idle after reset");
    AST_RD_ANSWER_ONCE: assert property (rd_en ##1 rvalid |=> !rvalid [*2])
        else $error("second answer for one read");
endmodule
`default_nettype wire

// [sim/tb_flash_program_cmd_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_program_cmd_fsm;
    import fpc_pkg::*;
    logic clk, nrst, cmd_valid, cmd_rd, cmd_ready, resp_valid;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data, resp_data, array_data, lock_data, status_word, d;
    logic prog_start, prog_done, abort_event, busy, suspended, lock_prog;
    logic [DATA_W-1:0] rq[$];
    logic [DATA_W-1:0] lq[$];
    int failures = 0;
    int total_checks = 0;

    fpc_bus_if fpc_bus_if_i();
    fpc_host fpc_host_i(.clk(clk), .nrst(nrst), .bus(fpc_bus_if_i), .cmd_valid(cmd_valid),
        .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_data(resp_data));
    fpc_device #(.SUSP_LAT_CYC(4)) fpc_device_i(.clk(clk), .nrst(nrst), .bus(fpc_bus_if_i),
        .prog_start(prog_start), .prog_done(prog_done), .abort_event(abort_event),
        .array_data(array_data), .busy(busy), .suspended(suspended), .lock_prog(lock_prog),
        .lock_data(lock_data), .status_word(status_word));
    fpc_checker fpc_checker_i(.clk(clk), .nrst(nrst), .wr_en(fpc_bus_if_i.wr_en),
        .rd_en(fpc_bus_if_i.rd_en), .addr(fpc_bus_if_i.addr), .wdata(fpc_bus_if_i.wdata),
        .rdata(fpc_bus_if_i.rdata), .rvalid(fpc_bus_if_i.rvalid));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One host write, ends after the device has taken it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        cmd_rd = 1'b0;
        cmd_addr = a;
        cmd_data = v;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        @(negedge clk);
    endtask

    // One host read, expected byte noted for the monitor
    task automatic rd(input logic [DATA_W-1:0] exp);
        rq.push_back(exp);
        cmd_rd = 1'b1;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        check("cmd_ready", cmd_ready, 1'b0);
        repeat (4) @(negedge clk);
        check("cmd_ready", cmd_ready, 1'b1);
    endtask

    task automatic pls(input int k);
        {abort_event, prog_done, prog_start} = 3'(1 << k);
        @(negedge clk);
        {abort_event, prog_done, prog_start} = 3'h0;
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        if (resp_valid === 1'b1) begin
            if (rq.size() > 0) begin
                check("resp_data", resp_data, rq.pop_front());
            end else begin
                failures++;
                $display("Error resp_data expected none seen %h", resp_data);
            end
        end
        if (lock_prog === 1'b1) begin
            if (lq.size() > 0) begin
                check("lock_data", lock_data, lq.pop_front());
            end else begin
                failures++;
                $display("Error lock_data expected none seen %h", lock_data);
            end
        end
    end

    initial begin
        #(25 * 5000);
        failures++;
        print_verdict();
    end

    initial begin
        {cmd_valid, cmd_rd, prog_start, prog_done, abort_event} = 5'h00;
        cmd_addr = ADDR_RST;
        cmd_data = 8'h00;
        array_data = 8'h00;
        nrst = 1'b0;
        void'($urandom(32'h95b6_f55d));
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check("status_word", status_word, 8'h80);
        array_data = DATA_W'($urandom);
        rd(array_data);
        pls(0);
        check("busy", busy, 1'b1);
        pls(1);
        check("busy", busy, 1'b0);
        // Status read in mid-program
        pls(0);
        wr(ADDR_CMD1, CMD_SR_READ);
        rd(8'h00);
        array_data = DATA_W'($urandom);
        rd(array_data);
        check("busy", busy, 1'b1);
        // Both suspend and both resume codes
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_W'($urandom), i ? CMD_SUSP_LEGACY : CMD_SUSP_ENH);
            if (i == 0) begin
                repeat (3) @(negedge clk);
                check("suspended", suspended, 1'b0);
                @(negedge clk);
                check("suspended", suspended, 1'b1);
            end else begin
                // Status read while pending, latency expires on the read
                wr(ADDR_CMD1, CMD_SR_READ);
                rd(8'h00);
                check("suspended", suspended, 1'b1);
            end
            wr(ADDR_CMD1, CMD_SR_READ);
            rd(8'h84);
            array_data = DATA_W'($urandom);
            rd(array_data);
            wr(ADDR_CMD1, CMD_SR_CLEAR);
            check("suspended", suspended, 1'b1);
            wr(ADDR_W'($urandom), i ? CMD_RESUME_LEGACY : CMD_RESUME_ENH);
            check("busy", busy, 1'b1);
            check("suspended", suspended, 1'b0);
        end
        // Abort unlock: wrong address falls back, then bad data, then reset
        pls(2);
        check("abort_flag", status_word[SR_ABORT_BIT], 1'b1);
        wr(ADDR_CMD1, CMD_UNLOCK1);
        wr(12'h0123, CMD_UNLOCK2);
        wr(ADDR_CMD2, CMD_UNLOCK2);
        wr(ADDR_CMD2, 8'h00);
        check("busy", busy, 1'b0);
        wr(ADDR_CMD1, CMD_UNLOCK1);
        wr(ADDR_CMD2, CMD_UNLOCK2);
        wr(ADDR_CMD2, 8'h00);
        check("busy", busy, 1'b1);
        pls(1);
        check("abort_flag", status_word[SR_ABORT_BIT], 1'b1);
        wr(ADDR_CMD1, CMD_SR_CLEAR);
        check("abort_flag", status_word[SR_ABORT_BIT], 1'b0);
        pls(0);
        pls(2);
        wr(ADDR_CMD1, CMD_SR_READ);
        rd(8'h88);
        wr(ADDR_CMD1, CMD_UNLOCK1);
        wr(ADDR_CMD2, CMD_UNLOCK2);
        wr(ADDR_W'($urandom), CMD_RESET);
        check("busy", busy, 1'b0);
        check("abort_flag", status_word[SR_ABORT_BIT], 1'b0);
        // Lock command set, both ways out
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CMD1, CMD_LOCK_ENTER);
            wr(ADDR_CMD1, CMD_SR_READ);
            rd(8'h80);
            wr(ADDR_CMD1, CMD_SR_CLEAR);
            wr(ADDR_CMD1, CMD_LOCK_PGM);
            d = DATA_W'($urandom);
            lq.push_back(d);
            wr(ADDR_W'($urandom), d);
            pls(0);
            check("busy", busy, 1'b0);
            if (i == 0) begin
                wr(ADDR_W'($urandom), CMD_EXIT_ENTRY);
                wr(ADDR_W'($urandom), CMD_EXIT);
            end else begin
                wr(ADDR_W'($urandom), CMD_RESET);
            end
            pls(0);
            check("busy", busy, 1'b1);
            pls(1);
        end
        // Program ends during a status read
        pls(0);
        wr(ADDR_CMD1, CMD_SR_READ);
        pls(1);
        rd(8'h80);
        check("busy", busy, 1'b0);
        repeat (4) @(negedge clk);
        check("reads pending", DATA_W'(rq.size()), 8'h00);
        check("lock writes pending", DATA_W'(lq.size()), 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
